// File: shared/rtc_params.svh
// Constants for the rotate-through-carry unit
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

// ==========================================
// Opcode fields
`define RTC_OPC_HI 13
`define RTC_OPC_LO 8
`define RTC_DEST_BIT 7
`define RTC_ADDR_HI 6
`define RTC_ROTATE_LEFT_CARRY_OP 6'h0d
`define RTC_ROTATE_RIGHT_CARRY_OP 6'h0c

// ==========================================
// Reset values
`define RTC_W_RESET 8'h00
`define RTC_C_RESET 1'h0

`endif

// File: shared/rtc_pkg.sv
// Types for the rotate-through-carry unit
package rtc_pkg;

    // ==========================================
    // Instruction phases, one-hot
    typedef enum logic [3:0] {
        RTC_PH_DECODE = 4'h1,
        RTC_PH_READ = 4'h2,
        RTC_PH_PROC = 4'h4,
        RTC_PH_WRITE = 4'h8
    } rtc_phase_t;

    // Decoded instruction word
    typedef struct packed {
        logic [5:0] opcode;
        logic dest;
        logic [6:0] addr;
    } rtc_instr_t;

    // Data memory write request
    typedef struct packed {
        logic en;
        logic [6:0] addr;
        logic [7:0] data;
    } rtc_mem_wr_t;

endpackage : rtc_pkg

// File: design/rtc_unit.sv
// Rotate-through-carry execution unit
`timescale 1ns/10ps
`include "rtc_params.svh"

module rtc_unit
    import rtc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Instruction from decoder
    input wire logic instr_valid_i,
    input wire logic [13:0] instr_i,
    // Data memory read
    output logic [6:0] mem_raddr_o,
    input wire logic [7:0] mem_rdata_i,
    // Data memory write
    output rtc_mem_wr_t mem_wr_o,
    // Core state
    output logic [7:0] w_o,
    output logic carry_o,
    output logic busy_o,
    output logic done_o
);

    // ==========================================
    // Helpers

    function automatic logic [8:0] rot_carry(input logic left, input logic [7:0] v,
                                             input logic c);
        logic [8:0] r;
        r = 9'h000;
        if (left) begin
            r = {v[7], v[6:0], c};
        end else begin
            r = {v[0], c, v[7:1]};
        end
        return r;
    endfunction : rot_carry

    // True for either rotate opcode
    function automatic logic is_rot(input logic [5:0] op);
        return (op == `RTC_ROTATE_LEFT_CARRY_OP) || (op == `RTC_ROTATE_RIGHT_CARRY_OP);
    endfunction : is_rot

    // True for the left rotate opcode
    function automatic logic is_left(input logic [5:0] op);
        return op == `RTC_ROTATE_LEFT_CARRY_OP;
    endfunction : is_left

    // ==========================================
    // State

    // Current phase and latched word
    rtc_phase_t phase_q, phase_d;
    rtc_instr_t ins_q, ins_d;
    // Datapath: source byte, rotated byte, carry out
    logic [7:0] opnd_q, opnd_d;
    logic [7:0] res_q, res_d;
    logic cres_q, cres_d;
    // Accumulator and carry flag
    logic [7:0] w_q, w_d;
    logic c_q, c_d;
    // Write request and completion pulse
    rtc_mem_wr_t wr_q, wr_d;
    logic done_q, done_d;
    // Word accepted at this edge
    logic take;

    // Only a rotate word in the decode phase is taken; others pass unseen
    assign take = (phase_q == RTC_PH_DECODE) && instr_valid_i
                  && is_rot(instr_i[`RTC_OPC_HI:`RTC_OPC_LO]);

    // ==========================================
    // Phase sequencer

    always_comb begin
        phase_d = phase_q;
        case (phase_q)
            RTC_PH_DECODE: begin
                if (take) begin
                    phase_d = RTC_PH_READ;
                end
            end
            RTC_PH_READ: begin
                phase_d = RTC_PH_PROC;
            end
            RTC_PH_PROC: begin
                phase_d = RTC_PH_WRITE;
            end
            RTC_PH_WRITE: begin
                phase_d = RTC_PH_DECODE;
            end
            default: begin
                // An illegal code recovers to decode
                phase_d = RTC_PH_DECODE;
            end
        endcase
    end

    // Phase register
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            phase_q <= RTC_PH_DECODE;
        end else begin
            phase_q <= phase_d;
        end
    end

    // ==========================================
    // Instruction latch

    // word held for the whole cycle
    always_comb begin
        ins_d = ins_q;
        if (take) begin
            ins_d = rtc_instr_t'(instr_i);
        end
    end

    // Instruction register; also drives the read address
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ins_q <= '0;
        end else begin
            ins_q <= ins_d;
        end
    end

    // ==========================================
    // Operand and rotator

    // read, then rotate in the next phase
    always_comb begin
        opnd_d = opnd_q;
        res_d = res_q;
        cres_d = cres_q;
        if (phase_q == RTC_PH_READ) begin
            // Source byte sampled at the end of the read phase
            opnd_d = mem_rdata_i;
        end
        if (phase_q == RTC_PH_PROC) begin
            {cres_d, res_d} = rot_carry(is_left(ins_q.opcode), opnd_q, c_q);
        end
    end

    // Operand and result registers
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            opnd_q <= 8'h00;
            res_q <= 8'h00;
            cres_q <= `RTC_C_RESET;
        end else begin
            opnd_q <= opnd_d;
            res_q <= res_d;
            cres_q <= cres_d;
        end
    end

    // ==========================================
    // Accumulator and carry

    // Carry settles in the write phase, before the next rotate reads it
    always_comb begin
        w_d = w_q;
        c_d = c_q;
        if (phase_q == RTC_PH_WRITE) begin
            c_d = cres_q;
            if (!ins_q.dest) begin
                w_d = res_q;
            end
        end
    end

    // Accumulator and carry registers
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            w_q <= `RTC_W_RESET;
            c_q <= `RTC_C_RESET;
        end else begin
            w_q <= w_d;
            c_q <= c_d;
        end
    end

    // ==========================================
    // Write port and completion

    // Write request and done are one-cycle pulses
    always_comb begin
        wr_d = '0;
        done_d = 1'h0;
        if (phase_q == RTC_PH_WRITE) begin
            if (ins_q.dest) begin
                wr_d.en = 1'h1;
                wr_d.addr = ins_q.addr;
                wr_d.data = res_q;
            end
            done_d = 1'h1;
        end
    end

    // Write request and done registers
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_q <= '0;
            done_q <= 1'h0;
        end else begin
            wr_q <= wr_d;
            done_q <= done_d;
        end
    end

    // ==========================================
    // Outputs

    // Registered data, combinational busy
    assign mem_raddr_o = ins_q.addr;
    assign mem_wr_o = wr_q;
    assign w_o = w_q;
    assign carry_o = c_q;
    assign busy_o = (phase_q != RTC_PH_DECODE); // Handshake, combinational
    assign done_o = done_q;

endmodule : rtc_unit

// File: sim/rtc_mem_model.sv
// Data memory model facing the rotate unit
`timescale 1ns/10ps
module rtc_mem_model
    import rtc_pkg::*;
(
    // Clock, read and write ports
    input wire logic clk_i,
    input wire logic [6:0] raddr_i,
    output logic [7:0] rdata_o,
    input wire rtc_mem_wr_t wr_i
);
    logic [7:0] m [128];
    // Combinational read, clocked write
    assign rdata_o = m[raddr_i];
    always @(posedge clk_i) if (wr_i.en) m[wr_i.addr] <= wr_i.data;
endmodule : rtc_mem_model

// File: sim/rtc_unit_properties.sv
// Assertions for the rotate unit
`timescale 1ns/10ps
module rtc_unit_properties
    import rtc_pkg::*;
(
    // Unit ports
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic instr_valid_i,
    input wire logic [13:0] instr_i,
    input wire logic [6:0] mem_raddr_o,
    input wire logic [7:0] mem_rdata_i,
    input wire rtc_mem_wr_t mem_wr_o,
    input wire logic [7:0] w_o,
    input wire logic carry_o,
    input wire logic busy_o,
    input wire logic done_o
);
    // Taken request and visible result
    wire tk = !busy_o && instr_valid_i && instr_i[13:9] == 5'h06;
    wire [7:0] res = mem_wr_o.en ? mem_wr_o.data : w_o;
    logic [13:0] op;
    // Word held from its taking edge until done
    always_ff @(posedge clk_i) begin
        if (tk) op <= instr_i;
    end
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    cycle_len_a: assert property (tk |=> busy_o [*3] ##1 done_o && !busy_o)
        else $error("wrong cycle length");
    rot_left_a: assert property (done_o && op[8] |->
        {carry_o, res} == {$past(mem_rdata_i, 3), $past(carry_o, 4)}) else $error("left bad");
    rot_right_a: assert property (done_o && !op[8] |->
        {res, carry_o} == {$past(carry_o, 4), $past(mem_rdata_i, 3)}) else $error("right bad");
    dest_w_a: assert property (done_o && !op[7] |-> !mem_wr_o.en)
        else $error("stray write");
    dest_f_a: assert property (done_o && op[7] |-> mem_wr_o.en && mem_wr_o.addr == op[6:0]
        && $stable(w_o)) else $error("write missing");
    cover property (tk && instr_i[8]);
    cover property (tk && !instr_i[8]);
    cover property (done_o && mem_wr_o.en);
endmodule : rtc_unit_properties
bind rtc_unit rtc_unit_properties rtc_unit_properties_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .mem_raddr_o(mem_raddr_o),
    .mem_rdata_i(mem_rdata_i), .mem_wr_o(mem_wr_o), .w_o(w_o), .carry_o(carry_o),
    .busy_o(busy_o), .done_o(done_o));

// File: sim/testbench.sv
// Self-checking bench for the rotate unit
`timescale 1ns/10ps
module testbench;
    import rtc_pkg::*;
    logic clk_i = 0, reset_n_i = 0, instr_valid_i = 0, carry_o, busy_o, done_o, c = 0, nc;
    logic [13:0] instr_i = 14'h0000, ins;
    logic [6:0] mem_raddr_o;
    logic [7:0] mem_rdata_i, w_o, w = 8'h00, v, r, m [128];
    rtc_mem_wr_t mem_wr_o;
    int n_mismatch = 0, num_checks = 0, k;
    always #2 clk_i = ~clk_i;
    rtc_unit rtc_unit_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .mem_raddr_o(mem_raddr_o), .mem_rdata_i(mem_rdata_i),
        .mem_wr_o(mem_wr_o), .w_o(w_o), .carry_o(carry_o), .busy_o(busy_o), .done_o(done_o));
    rtc_mem_model rtc_mem_model_i (.clk_i(clk_i), .raddr_i(mem_raddr_o),
        .rdata_o(mem_rdata_i), .wr_i(mem_wr_o));
    task chk(input string s, input logic [15:0] e, g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task summarize;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize
    // Memory fill, reset, then back-to-back rotates
    initial begin
        void'($urandom(84));
        for (k = 0; k < 128; k++) m[k] = 8'($urandom);
        for (k = 0; k < 128; k++) rtc_mem_model_i.m[k] = m[k];
        repeat (5) @(posedge clk_i);
        #1 reset_n_i = 1;
        repeat (300) begin
            instr_i = {($urandom % 4 == 0) ? 5'h07 : 5'h06, 9'($urandom)};
            instr_valid_i = 1;
            ins = instr_i;
            @(posedge clk_i) #1;
            if (ins[13:9] != 5'h06) chk("idle", 16'h0, 16'(busy_o));
            if (ins[13:9] != 5'h06) continue;
            chk("busy", 16'h1, 16'(busy_o));
            chk("raddr", 16'(ins[6:0]), 16'(mem_raddr_o));
            v = m[ins[6:0]];
            {nc, r} = ins[8] ? {v, c} : {v[0], c, v[7:1]};
            instr_i = {5'h06, 9'($urandom)};
            repeat (2) @(posedge clk_i);
            #1 instr_valid_i = 0;
            for (k = 0; k < 8 && done_o !== 1; k++) @(posedge clk_i) #1;
            c = nc;
            if (ins[7]) m[ins[6:0]] = r;
            else w = r;
            chk("lat", 16'h1, 16'(k));
            chk("w", 16'(w), 16'(w_o));
            chk("c", 16'(c), 16'(carry_o));
            chk("wr", ins[7] ? {1'b1, ins[6:0], r} : 16'h0, ins[7] ? mem_wr_o : 16'(mem_wr_o.en));
            if (k == 8) summarize();
        end
        summarize();
    end
endmodule : testbench
